// file: design/iaf_pkg.sv
// Shared types and constants for the ingress access-list filter.
package iaf_pkg;

   // ------------------------------------------------------------------
   // Table geometry
   // ------------------------------------------------------------------
   localparam int N_ENTRY = 16;
   localparam int ENT_W   = 4;
   localparam int N_PORT  = 3;
   localparam int PORT_W  = 2;
   localparam int CNT_W   = 11;
   localparam int ACT_W   = 11;
   localparam int MAC_W   = 48;
   localparam int TYPE_W  = 16;
   localparam int IP_W    = 32;
   localparam int L4P_W   = 16;
   localparam int FLAG_W  = 8;
   localparam int PROT_W  = 8;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam longint CLK_HZ      = 25_000_000;
   localparam longint TICK_US     = 1000;
   localparam int     TICK_CYC_DF = int'((TICK_US * CLK_HZ) / 1_000_000);

   // ------------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_L2  = 2'h1;
   localparam logic [1:0] MODE_L3  = 2'h2;
   localparam logic [1:0] MODE_L4  = 2'h3;

   localparam logic [1:0] SUB_L2_CNT  = 2'h0;
   localparam logic [1:0] SUB_L2_TYPE = 2'h1;
   localparam logic [1:0] SUB_L2_MAC  = 2'h2;
   localparam logic [1:0] SUB_L2_BOTH = 2'h3;
   localparam logic [1:0] SUB_L3_MASK = 2'h1;
   localparam logic [1:0] SUB_L3_PAIR = 2'h2;
   localparam logic [1:0] SUB_L4_PROT = 2'h0;
   localparam logic [1:0] SUB_L4_TCP  = 2'h1;
   localparam logic [1:0] SUB_L4_UDP  = 2'h2;
   localparam logic [1:0] SUB_L4_SEQ  = 2'h3;

   localparam logic [1:0] CFG_MATCH  = 2'h0;
   localparam logic [1:0] CFG_ACTION = 2'h1;
   localparam logic [1:0] CFG_LINK   = 2'h2;

   localparam logic [1:0] FWD_NONE    = 2'h0;
   localparam logic [1:0] FWD_REPLACE = 2'h1;
   localparam logic [1:0] FWD_AND     = 2'h2;
   localparam logic [1:0] FWD_OR      = 2'h3;

   // Action word layout.
   localparam int ACT_FWD_HI  = 10;
   localparam int ACT_FWD_LO  = 9;
   localparam int ACT_PRIO_EN = 8;
   localparam int ACT_PRIO_HI = 7;
   localparam int ACT_PRIO_LO = 6;
   localparam int ACT_MAP_HI  = 2;
   localparam int ACT_MAP_LO  = 0;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]        match_mode;
      logic [1:0]        match_sub_select;
      logic              src_sel;
      logic              cnt_wdog;
      logic [MAC_W-1:0]  key_a;
      logic [TYPE_W-1:0] key_b;
      logic [IP_W-1:0]   mask;
   } iaf_match_t;

   typedef struct packed {
      logic [MAC_W-1:0]  dmac;
      logic [MAC_W-1:0]  smac;
      logic [TYPE_W-1:0] etype;
      logic              is_ipv4;
      logic [IP_W-1:0]   sip;
      logic [IP_W-1:0]   dip;
      logic [PROT_W-1:0] proto;
      logic              is_tcp;
      logic              is_udp;
      logic [L4P_W-1:0]  sport;
      logic [L4P_W-1:0]  dport;
      logic [FLAG_W-1:0] tcp_flags;
      logic [IP_W-1:0]   tcp_seq;
   } iaf_hdr_t;

endpackage : iaf_pkg

// file: design/iaf_hdr_if.sv
// Carrier for the parsed frame header inside the filter.
`timescale 1ns/10ps
interface iaf_hdr_if;
   import iaf_pkg::*;
   iaf_hdr_t hdr;
   modport drv (output hdr);
   modport snk (input hdr);
endinterface : iaf_hdr_if

// file: design/iaf_match_eval.sv
// One comparison entry evaluated against the current frame header.
`timescale 1ns/10ps
module iaf_match_eval
   import iaf_pkg::*;
(
   input  wire iaf_match_t i_entry,
   iaf_hdr_if.snk          hdr,
   output logic            o_hit
);

   logic [MAC_W-1:0] mac_sel;
   logic [IP_W-1:0]  ip_sel;
   logic [L4P_W-1:0] port_sel;
   logic             mac_eq;
   logic             type_eq;
   logic             flag_ok;

   assign mac_sel  = i_entry.src_sel ? hdr.hdr.smac : hdr.hdr.dmac;
   assign ip_sel   = i_entry.src_sel ? hdr.hdr.sip : hdr.hdr.dip;
   assign port_sel = i_entry.src_sel ? hdr.hdr.sport : hdr.hdr.dport;
   assign mac_eq   = (mac_sel == i_entry.key_a);
   assign type_eq  = (hdr.hdr.etype == i_entry.key_b);
   // A zero flag mask leaves the flags out of the TCP port test.
   assign flag_ok  = ((hdr.hdr.tcp_flags ^ i_entry.key_a[FLAG_W-1:0])
                      & i_entry.mask[FLAG_W-1:0]) == '0;

   always_comb
   begin
      o_hit = 1'b0;
      case (i_entry.match_mode)
         MODE_L2:
         begin
            case (i_entry.match_sub_select)
               SUB_L2_TYPE: o_hit = type_eq;
               SUB_L2_MAC:  o_hit = mac_eq;
               default:     o_hit = mac_eq & type_eq;
            endcase
         end
         MODE_L3:
         begin
            case (i_entry.match_sub_select)
               SUB_L3_MASK: o_hit = hdr.hdr.is_ipv4 &
                                    (((ip_sel ^ i_entry.key_a[IP_W-1:0]) & i_entry.mask) == '0);
               SUB_L3_PAIR: o_hit = hdr.hdr.is_ipv4 &
                                    (hdr.hdr.sip == i_entry.key_a[IP_W-1:0]) &
                                    (hdr.hdr.dip == i_entry.mask);
               default:     o_hit = 1'b0;
            endcase
         end
         MODE_L4:
         begin
            case (i_entry.match_sub_select)
               SUB_L4_PROT: o_hit = hdr.hdr.is_ipv4 &
                                    (hdr.hdr.proto == i_entry.key_b[PROT_W-1:0]);
               SUB_L4_TCP:  o_hit = hdr.hdr.is_ipv4 & hdr.hdr.is_tcp &
                                    (port_sel == i_entry.key_b) & flag_ok;
               SUB_L4_UDP:  o_hit = hdr.hdr.is_ipv4 & hdr.hdr.is_udp &
                                    (port_sel == i_entry.key_b);
               default:     o_hit = hdr.hdr.is_ipv4 & hdr.hdr.is_tcp &
                                    (hdr.hdr.tcp_seq == i_entry.key_a[IP_W-1:0]);
            endcase
         end
         default: o_hit = 1'b0;
      endcase
   end

endmodule : iaf_match_eval

// file: design/iaf_act_mem.sv
// Action table storage with a registered read port.
`timescale 1ns/10ps
module iaf_act_mem #(
   parameter int DATA_W = 11,
   parameter int ADDR_W = 6
) (
   input  wire logic              i_clk,
   input  wire logic              i_we,
   input  wire logic [ADDR_W-1:0] i_waddr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_re,
   input  wire logic [ADDR_W-1:0] i_raddr,
   output logic      [DATA_W-1:0] o_rdata
);

   logic [DATA_W-1:0] mem [2**ADDR_W];

   always_ff @(posedge i_clk)
   begin
      if (i_we)
         mem[i_waddr] <= i_wdata;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_re)
         o_rdata <= mem[i_raddr];
   end

endmodule : iaf_act_mem

// file: design/iaf_filter.sv
// Top of the per-port ingress access-list filter engine.
`timescale 1ns/10ps
module iaf_filter
   import iaf_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DF
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   // Table programming.
   input  wire logic                    i_cfg_we,
   input  wire logic [1:0]              i_cfg_sel,
   input  wire logic [PORT_W-1:0]       i_cfg_port,
   input  wire logic [ENT_W-1:0]        i_cfg_idx,
   input  wire iaf_match_t              i_cfg_match,
   input  wire logic [ACT_W-1:0]        i_cfg_action,
   input  wire logic [ENT_W-1:0]        i_cfg_action_pointer,
   input  wire logic [N_ENTRY-1:0]      i_cfg_match_select_mask,
   // Frame from the receive parser.
   input  wire logic                    i_frm_valid,
   input  wire logic [PORT_W-1:0]       i_frm_port,
   input  wire iaf_hdr_t                i_frm_hdr,
   // Decision to the forwarding logic.
   output logic                         o_dec_valid,
   output logic                         o_dec_hit,
   output logic                         o_dec_override,
   output logic [1:0]                   o_dec_fwd_mode,
   output logic [N_PORT-1:0]            o_dec_port_map,
   output logic                         o_dec_prio_en,
   output logic [1:0]                   o_dec_prio,
   output logic [ENT_W-1:0]             o_dec_action_idx,
   // Counter events.
   input  wire logic [N_PORT*N_ENTRY-1:0] i_cnt_clear,
   output logic [N_PORT*N_ENTRY-1:0]    o_cnt_flag,
   output logic                         o_cnt_irq
);

   localparam int TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam int MADDR_W = PORT_W + ENT_W;

   // ------------------------------------------------------------------
   // Table storage
   // ------------------------------------------------------------------
   // Tables are flops: every entry is read at once.
   // Only action words, read once a frame, use RAM.
   iaf_match_t       match_tab  [N_PORT][N_ENTRY];
   logic [ENT_W-1:0]   link_ptr   [N_PORT][N_ENTRY];
   logic [N_ENTRY-1:0] link_mask  [N_PORT][N_ENTRY];
   logic [CNT_W-1:0]   cnt_limit  [N_PORT][N_ENTRY];
   logic [CNT_W-1:0]   cnt_run    [N_PORT][N_ENTRY];
   logic [CNT_W-1:0]   next_cnt   [N_PORT][N_ENTRY];
   logic [N_PORT*N_ENTRY-1:0] cnt_fire;
   logic [N_PORT*N_ENTRY-1:0] next_flag;

   // Working signals of the frame now presented.
   logic                 cfg_port_ok;
   logic                 port_ok;
   logic [PORT_W-1:0]    fp;
   logic [N_ENTRY-1:0]   hit;
   logic [N_ENTRY-1:0]   act_is_cnt;
   logic [N_ENTRY-1:0]   act_hit;
   logic [ENT_W-1:0]     win;
   logic                 any_hit;
   logic [ACT_W-1:0]     act_word;
   logic                 s1_valid;
   logic                 s1_hit;
   logic [ENT_W-1:0]     s1_win;
   logic [TICK_W-1:0]    tick_cnt;
   logic                 tick;

   assign cfg_port_ok = (i_cfg_port < PORT_W'(N_PORT));
   assign port_ok     = (i_frm_port < PORT_W'(N_PORT));
   // An unknown port index falls back to list 0 but never produces a hit.
   assign fp          = port_ok ? i_frm_port : '0;

   // Writes to port 3 or select 3 are dropped, so
   // software cannot touch a list that does not exist.

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         for (int p = 0; p < N_PORT; p++)
            for (int e = 0; e < N_ENTRY; e++)
            begin
               match_tab[p][e] <= '0;
               link_ptr[p][e]  <= '0;
               link_mask[p][e] <= '0;
               cnt_limit[p][e] <= '0;
            end
      end
      else if (i_cfg_we && cfg_port_ok)
      begin
         case (i_cfg_sel)
            CFG_MATCH:  match_tab[i_cfg_port][i_cfg_idx] <= i_cfg_match;
            // The counters need every limit at once, so a copy sits beside the RAM.
            CFG_ACTION: cnt_limit[i_cfg_port][i_cfg_idx] <= i_cfg_action[CNT_W-1:0];
            CFG_LINK:
            begin
               link_ptr[i_cfg_port][i_cfg_idx]  <= i_cfg_action_pointer;
               link_mask[i_cfg_port][i_cfg_idx] <= i_cfg_match_select_mask;
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Comparison stage
   // ------------------------------------------------------------------
   iaf_hdr_if hdr_bus ();
   assign hdr_bus.hdr = i_frm_hdr;

   // Comparators watch the list of the frame's port.
   generate
      for (genvar g = 0; g < N_ENTRY; g++)
      begin : g_match
         iaf_match_eval u_eval (
            .i_entry (match_tab[fp][g]),
            .hdr     (hdr_bus),
            .o_hit   (hit[g])
         );
         assign act_is_cnt[g] = (match_tab[fp][g].match_mode == MODE_L2) &&
                                (match_tab[fp][g].match_sub_select == SUB_L2_CNT);
      end
   endgenerate

   // ------------------------------------------------------------------
   // Linking and priority
   // ------------------------------------------------------------------
   // Every qualifying link marks its action.
   always_comb
   begin
      act_hit = '0;
      for (int l = 0; l < N_ENTRY; l++)
      begin
         // An empty mask leaves the link inert; a link aimed at a counter slot
         // is dropped because that slot holds a count, not an action.
         if ((link_mask[fp][l] != '0) &&
             ((link_mask[fp][l] & ~hit) == '0) &&
             !act_is_cnt[link_ptr[fp][l]])
            act_hit[link_ptr[fp][l]] = 1'b1;
      end
   end

   // The lowest marked action index wins.
   always_comb
   begin
      win = '0;
      for (int j = N_ENTRY - 1; j >= 0; j--)
         if (act_hit[j])
            win = ENT_W'(j);
      any_hit = port_ok && (act_hit != '0);
   end

   iaf_act_mem #(
      .DATA_W (ACT_W),
      .ADDR_W (MADDR_W)
   ) u_act_mem (
      .i_clk   (i_clk),
      .i_we    (i_cfg_we && cfg_port_ok && (i_cfg_sel == CFG_ACTION)),
      .i_waddr ({i_cfg_port, i_cfg_idx}),
      .i_wdata (i_cfg_action),
      .i_re    (i_frm_valid),
      .i_raddr ({fp, win}),
      .o_rdata (act_word)
   );

   // Stage 1 holds the result of the frame while
   // the action RAM reads the winning word.

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         s1_valid <= 1'b0;
         s1_hit   <= 1'b0;
         s1_win   <= '0;
      end
      else
      begin
         s1_valid <= i_frm_valid;
         s1_hit   <= i_frm_valid && any_hit;
         s1_win   <= win;
      end
   end

   // A miss clears the fields so no stale action leaks.
   // Fixed latency: the decision stands two edges after the frame is taken.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_dec_valid      <= 1'b0;
         o_dec_hit        <= 1'b0;
         o_dec_override   <= 1'b0;
         o_dec_fwd_mode   <= FWD_NONE;
         o_dec_port_map   <= '0;
         o_dec_prio_en    <= 1'b0;
         o_dec_prio       <= '0;
         o_dec_action_idx <= '0;
      end
      else
      begin
         o_dec_valid      <= s1_valid;
         o_dec_hit        <= s1_hit;
         o_dec_action_idx <= s1_hit ? s1_win : '0;
         o_dec_fwd_mode   <= s1_hit ? act_word[ACT_FWD_HI:ACT_FWD_LO] : FWD_NONE;
         o_dec_override   <= s1_hit && (act_word[ACT_FWD_HI:ACT_FWD_LO] != FWD_NONE);
         o_dec_port_map   <= s1_hit ? act_word[ACT_MAP_HI:ACT_MAP_LO] : '0;
         o_dec_prio_en    <= s1_hit && act_word[ACT_PRIO_EN];
         o_dec_prio       <= s1_hit ? act_word[ACT_PRIO_HI:ACT_PRIO_LO] : '0;
      end
   end

   // ------------------------------------------------------------------
   // Counter operation
   // ------------------------------------------------------------------
   // Watchdog time base: one tick every TICK_CYC
   // cycles, shared by all watchdog entries.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end
      else if (tick_cnt == TICK_W'(TICK_CYC - 1))
      begin
         tick_cnt <= '0;
         tick     <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 1'b1;
         tick     <= 1'b0;
      end
   end

   // Both counter kinds count up toward the limit: the watchdog counts ticks
   // and restarts on every matching frame, the event counter counts frames.
   always_comb
   begin
      logic             is_cnt;
      logic             seen;
      logic             step;
      logic [CNT_W:0]   inc;
      is_cnt   = 1'b0;
      seen     = 1'b0;
      step     = 1'b0;
      inc      = '0;
      cnt_fire = '0;
      for (int p = 0; p < N_PORT; p++)
         for (int e = 0; e < N_ENTRY; e++)
         begin
            is_cnt = (match_tab[p][e].match_mode == MODE_L2) &&
                     (match_tab[p][e].match_sub_select == SUB_L2_CNT);
            seen   = i_frm_valid && port_ok && (fp == PORT_W'(p)) && hit[e];
            step   = match_tab[p][e].cnt_wdog ? tick : seen;
            inc    = {1'b0, cnt_run[p][e]} + 1'b1;
            next_cnt[p][e] = cnt_run[p][e];
            if (i_cfg_we && (i_cfg_port == PORT_W'(p)) && (i_cfg_idx == ENT_W'(e)) &&
                ((i_cfg_sel == CFG_MATCH) || (i_cfg_sel == CFG_ACTION)))
               next_cnt[p][e] = '0;
            else if (!is_cnt)
               next_cnt[p][e] = '0;
            else if (match_tab[p][e].cnt_wdog && seen)
               next_cnt[p][e] = '0;
            else if (step)
            begin
               if (inc >= {1'b0, cnt_limit[p][e]})
               begin
                  cnt_fire[p*N_ENTRY+e] = 1'b1;
                  next_cnt[p][e] = '0;
               end
               else
                  next_cnt[p][e] = inc[CNT_W-1:0];
            end
         end
   end

   // Sticky flags: set by a fire, dropped by a clear.
   // A fire in the same cycle as a clear keeps the flag set.
   assign next_flag = (o_cnt_flag & ~i_cnt_clear) | cnt_fire;

   // Running counts of every entry of every list.

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         for (int p = 0; p < N_PORT; p++)
            for (int e = 0; e < N_ENTRY; e++)
               cnt_run[p][e] <= '0;
      end
      else
      begin
         for (int p = 0; p < N_PORT; p++)
            for (int e = 0; e < N_ENTRY; e++)
               cnt_run[p][e] <= next_cnt[p][e];
      end
   end

   // The interrupt summary moves on the same edge
   // as the flags it summarises.

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_cnt_flag <= '0;
         o_cnt_irq  <= 1'b0;
      end
      else
      begin
         o_cnt_flag <= next_flag;
         o_cnt_irq  <= (next_flag != '0);
      end
   end

endmodule : iaf_filter

// file: verification/iaf_filter_asserts.sv
// Concurrent checks on the ports of the ingress filter.
`timescale 1ns/10ps
module iaf_filter_asserts
   import iaf_pkg::*;
(
   input wire logic                        i_clk,
   input wire logic                        i_rst,
   input wire logic                        i_frm_valid,
   input wire logic [PORT_W-1:0]           i_frm_port,
   input wire logic [N_PORT*N_ENTRY-1:0]   i_cnt_clear,
   input wire logic                        o_dec_valid,
   input wire logic                        o_dec_hit,
   input wire logic                        o_dec_override,
   input wire logic [1:0]                  o_dec_fwd_mode,
   input wire logic [N_PORT-1:0]           o_dec_port_map,
   input wire logic [ENT_W-1:0]            o_dec_action_idx,
   input wire logic [N_PORT*N_ENTRY-1:0]   o_cnt_flag,
   input wire logic                        o_cnt_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // Flags that must survive into the next cycle.
   logic [N_PORT*N_ENTRY-1:0] keep_q;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         keep_q <= '0;
      else
         keep_q <= o_cnt_flag & ~i_cnt_clear;
   end

   AST_DEC_LAT: assert property (i_frm_valid |-> ##2 o_dec_valid)
      else $error("decision missing two cycles after a frame");
   AST_DEC_CAUSE: assert property (o_dec_valid |-> $past(i_frm_valid, 2))
      else $error("decision without a frame");
   AST_OVR: assert property (o_dec_valid |->
      (o_dec_override == (o_dec_hit && (o_dec_fwd_mode != FWD_NONE))))
      else $error("override flag disagrees with hit and mode");
   AST_MISS_ZERO: assert property ((o_dec_valid && !o_dec_hit) |->
      (o_dec_fwd_mode == 2'h0 && o_dec_port_map == 3'h0 && o_dec_action_idx == 4'h0))
      else $error("action fields not zero on a miss");
   AST_PORT3: assert property ((i_frm_valid && i_frm_port == 2'h3) |->
      ##2 (o_dec_valid && !o_dec_hit))
      else $error("frame on unused port gave a hit");
   AST_IRQ: assert property (o_cnt_irq == (|o_cnt_flag))
      else $error("interrupt differs from flag summary");
   AST_STICKY: assert property ((o_cnt_flag & keep_q) == keep_q)
      else $error("counter flag dropped without clear");
   AST_RST_QUIET: assert property ($fell(i_rst) |-> (!o_dec_valid && !o_cnt_irq))
      else $error("outputs active right after reset");
endmodule : iaf_filter_asserts

bind iaf_filter iaf_filter_asserts iaf_filter_asserts_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_frm_valid(i_frm_valid), .i_frm_port(i_frm_port),
   .i_cnt_clear(i_cnt_clear), .o_dec_valid(o_dec_valid), .o_dec_hit(o_dec_hit),
   .o_dec_override(o_dec_override), .o_dec_fwd_mode(o_dec_fwd_mode),
   .o_dec_port_map(o_dec_port_map), .o_dec_action_idx(o_dec_action_idx),
   .o_cnt_flag(o_cnt_flag), .o_cnt_irq(o_cnt_irq));

// file: verification/iaf_rx_model.sv
// Receive parser and forwarding-side model facing the filter.
`timescale 1ns/10ps
module iaf_rx_model
   import iaf_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_dec_valid,
   input  wire logic              i_dec_hit,
   input  wire logic [ENT_W-1:0]  i_dec_idx,
   input  wire logic [N_PORT-1:0] i_dec_map,
   output logic                   o_frm_valid,
   output logic [PORT_W-1:0]      o_frm_port,
   output iaf_hdr_t               o_frm_hdr
);
   int                n_dec = 0;
   logic              hit = 1'b0;
   logic [ENT_W-1:0]  idx = '0;
   logic [N_PORT-1:0] map = '0;

   initial
   begin
      o_frm_valid = 1'b0;
      o_frm_port  = '0;
      o_frm_hdr   = '0;
   end

   // The header is only good in the valid cycle; afterwards it shows garbage.
   task automatic send(input logic [PORT_W-1:0] prt, input iaf_hdr_t h);
      @(posedge i_clk);
      o_frm_valid <= 1'b1;
      o_frm_port  <= prt;
      o_frm_hdr   <= h;
      @(posedge i_clk);
      o_frm_valid <= 1'b0;
      o_frm_hdr   <= ~h;
   endtask : send

   // The decision is a one-cycle pulse, so it is captured at that edge.
   always @(posedge i_clk)
   begin
      if (i_dec_valid)
      begin
         n_dec <= n_dec + 1;
         hit   <= i_dec_hit;
         idx   <= i_dec_idx;
         map   <= i_dec_map;
      end
   end
endmodule : iaf_rx_model

// file: verification/testbench.sv
// Self-checking bench for the ingress filter.
`timescale 1ns/10ps
module testbench;
   import iaf_pkg::*;
   localparam logic [47:0] MAC_A = 48'h0200_0000_00a1;
   localparam logic [47:0] MAC_B = 48'h0200_0000_00b2;
   localparam logic [10:0] ACT1  = {FWD_REPLACE, 1'b1, 2'h3, 3'h0, 3'h1};
   localparam logic [10:0] ACT2  = {FWD_OR, 1'b0, 2'h0, 3'h0, 3'h6};
   logic i_clk = 1'b0, i_rst = 1'b1, cfg_we = 1'b0, dec_valid, dec_hit, irq;
   logic [1:0] cfg_sel = '0, cfg_port = '0, frm_port;
   logic [3:0] cfg_idx = '0, cfg_ptr = '0, dec_idx;
   logic [10:0] cfg_act = '0;
   logic [15:0] cfg_mask = '0;
   logic [2:0] dec_map, dec_pri, pri_q;
   logic [47:0] cnt_clear = '0, cnt_flag;
   logic frm_valid;
   iaf_match_t cfg_match = '0;
   iaf_hdr_t frm_hdr;
   int failures = 0, tests_run = 0, cycles = 0;

   iaf_filter #(.TICK_CYC(4)) iaf_filter_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_cfg_we(cfg_we), .i_cfg_sel(cfg_sel),
      .i_cfg_port(cfg_port), .i_cfg_idx(cfg_idx), .i_cfg_match(cfg_match),
      .i_cfg_action(cfg_act), .i_cfg_action_pointer(cfg_ptr),
      .i_cfg_match_select_mask(cfg_mask), .i_frm_valid(frm_valid), .i_frm_port(frm_port),
      .i_frm_hdr(frm_hdr), .o_dec_valid(dec_valid), .o_dec_hit(dec_hit),
      .o_dec_override(), .o_dec_fwd_mode(), .o_dec_port_map(dec_map), .o_dec_prio_en(dec_pri[2]),
      .o_dec_prio(dec_pri[1:0]), .o_dec_action_idx(dec_idx), .i_cnt_clear(cnt_clear),
      .o_cnt_flag(cnt_flag), .o_cnt_irq(irq));

   iaf_rx_model iaf_rx_model_inst (
      .i_clk(i_clk), .i_dec_valid(dec_valid), .i_dec_hit(dec_hit), .i_dec_idx(dec_idx),
      .i_dec_map(dec_map), .o_frm_valid(frm_valid), .o_frm_port(frm_port),
      .o_frm_hdr(frm_hdr));

   always @(posedge i_clk)
      if (dec_valid)
         pri_q <= dec_pri;

   initial
   begin
      forever #20 i_clk = ~i_clk;
   end

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   function automatic iaf_match_t mt(input logic [1:0] md, input logic [1:0] sb,
      input logic wd, input logic [47:0] ka, input logic [15:0] kb, input logic [31:0] mk);
      mt = '{md, sb, 1'b1, wd, ka, kb, mk};
   endfunction : mt

   function automatic iaf_hdr_t hd(input logic [47:0] sa, input logic [15:0] ty,
      input logic [31:0] ip);
      hd = '0;
      hd.smac = sa;
      hd.etype = ty;
      hd.is_ipv4 = 1'b1;
      hd.sip = ip;
   endfunction : hd

   task automatic cfg(input logic [1:0] sel, input logic [1:0] prt, input logic [3:0] idx,
      input iaf_match_t m, input logic [10:0] a, input logic [3:0] p, input logic [15:0] k);
      @(posedge i_clk);
      cfg_we <= 1'b1;
      cfg_sel <= sel;
      cfg_port <= prt;
      cfg_idx <= idx;
      cfg_match <= m;
      cfg_act <= a;
      cfg_ptr <= p;
      cfg_mask <= k;
      @(posedge i_clk);
      cfg_we <= 1'b0;
   endtask : cfg

   task automatic frame(input logic [1:0] prt, input iaf_hdr_t h, input logic eh,
      input logic [3:0] ei, input logic [2:0] em, input logic [2:0] ep = 3'h0);
      int n0;
      int k;
      n0 = iaf_rx_model_inst.n_dec;
      iaf_rx_model_inst.send(prt, h);
      k = 0;
      while (iaf_rx_model_inst.n_dec == n0 && k < 8)
      begin
         @(posedge i_clk);
         k++;
      end
      #1;
      check("dec_seen", k < 8, 1'b1);
      check("dec_hit", iaf_rx_model_inst.hit, eh);
      check("dec_idx", iaf_rx_model_inst.idx, ei);
      check("dec_map", iaf_rx_model_inst.map, em);
      check("dec_prio", pri_q, ep);
   endtask : frame

   task automatic test_lists();
      cfg(CFG_MATCH, 2'h0, 4'h0, mt(MODE_L2, SUB_L2_MAC, 1'b0, MAC_A, '0, '0), '0, '0, '0);
      cfg(CFG_MATCH, 2'h0, 4'h1, mt(MODE_L2, SUB_L2_TYPE, 1'b0, '0, 16'h0800, '0), '0, '0, '0);
      cfg(CFG_MATCH, 2'h0, 4'h2, mt(MODE_L3, SUB_L3_MASK, 1'b0, 48'h0a00_0001, '0,
         32'hffff_ff00), '0, '0, '0);
      cfg(CFG_ACTION, 2'h0, 4'h1, '0, ACT1, '0, '0);
      cfg(CFG_ACTION, 2'h0, 4'h2, '0, ACT2, '0, '0);
      cfg(CFG_LINK, 2'h0, 4'h0, '0, '0, 4'h2, 16'h0001);
      cfg(CFG_LINK, 2'h0, 4'h1, '0, '0, 4'h1, 16'h0003);
      cfg(CFG_LINK, 2'h0, 4'h2, '0, '0, 4'h2, 16'h0004);
      cfg(CFG_LINK, 2'h0, 4'h3, '0, '0, 4'h3, 16'h0008);
      frame(2'h0, hd(MAC_A, 16'h0800, '0), 1'b1, 4'h1, 3'h1, 3'h7);
      frame(2'h0, hd(MAC_A, 16'h0806, '0), 1'b1, 4'h2, 3'h6);
      frame(2'h0, hd(MAC_B, 16'h0806, 32'h0a00_0005), 1'b1, 4'h2, 3'h6);
      frame(2'h1, hd(MAC_A, 16'h0800, '0), 1'b0, 4'h0, 3'h0);
      frame(2'h3, hd(MAC_A, 16'h0800, '0), 1'b0, 4'h0, 3'h0);
      cfg(CFG_MATCH, 2'h3, 4'h0, '0, '0, '0, '0);
      cfg(2'h3, 2'h0, 4'h1, '0, '0, '0, '0);
      frame(2'h0, hd(MAC_A, 16'h0800, '0), 1'b1, 4'h1, 3'h1, 3'h7);
   endtask : test_lists

   task automatic test_counter();
      cfg(CFG_MATCH, 2'h0, 4'h3, mt(MODE_L2, SUB_L2_CNT, 1'b0, MAC_B, 16'h88b5, '0),
         '0, '0, '0);
      cfg(CFG_ACTION, 2'h0, 4'h3, '0, 11'h002, '0, '0);
      frame(2'h0, hd(MAC_B, 16'h88b5, '0), 1'b0, 4'h0, 3'h0);
      check("event_flag", cnt_flag[3], 1'b0);
      frame(2'h0, hd(MAC_B, 16'h88b5, '0), 1'b0, 4'h0, 3'h0);
      check("event_flag", cnt_flag[3], 1'b1);
      check("irq", irq, 1'b1);
      @(posedge i_clk);
      cnt_clear <= 48'h8;
      @(posedge i_clk);
      cnt_clear <= '0;
      @(posedge i_clk);
      #1;
      check("flags", cnt_flag, '0);
   endtask : test_counter

   task automatic test_watchdog();
      cfg(CFG_ACTION, 2'h1, 4'h0, '0, 11'h003, '0, '0);
      cfg(CFG_MATCH, 2'h1, 4'h0, mt(MODE_L2, SUB_L2_CNT, 1'b1, MAC_B, 16'h88b5, '0),
         '0, '0, '0);
      repeat (6) frame(2'h1, hd(MAC_B, 16'h88b5, '0), 1'b0, 4'h0, 3'h0);
      check("wdog_flag", cnt_flag[16], 1'b0);
      repeat (20) @(posedge i_clk);
      #1;
      check("wdog_flag", cnt_flag[16], 1'b1);
   endtask : test_watchdog

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         stop_test();
      end
   end

   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      test_lists();
      test_counter();
      test_watchdog();
      stop_test();
   end
endmodule : testbench
